// File: core/sig_pkg.sv
// shared constants and carrier types of the signalling contact logic
package sig_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DELAY_MAX_STEPS = 10000;
  localparam int unsigned DELAY_W = 14;
  localparam int unsigned NUM_CONTACTS = 4;
  localparam int unsigned SRC_W = 4;

  // register map (byte addresses)
  localparam logic [7:0] ADDR_CONTACT0 = 8'h00;
  localparam logic [7:0] ADDR_CONTACT1 = 8'h04;
  localparam logic [7:0] ADDR_CONTACT2 = 8'h08;
  localparam logic [7:0] ADDR_CONTACT3 = 8'h0C;
  localparam logic [7:0] ADDR_INPUT_CFG = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
  localparam logic [7:0] ADDR_CMD = 8'h20;

  // contact config word fields
  localparam int unsigned CC_DELAY_LSB = 0;
  localparam int unsigned CC_SRC_LSB = 16;
  localparam int unsigned CC_NC_BIT = 20;
  localparam int unsigned CC_LATCH_BIT = 21;
  // input config word fields
  localparam int unsigned IC_DELAY_LSB = 0;
  localparam int unsigned IC_ACT_LSB = 16;
  localparam int unsigned IC_POL_BIT = 20;
  // command register bit: software contact reset
  localparam int unsigned CMD_RESET_BIT = 0;

  localparam logic [31:0] CONTACT_RESET = 32'h0000_0000;
  localparam logic [31:0] INPUT_RESET = 32'h0000_0000;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

  // irq bit positions: 0..3 contact activated, 4..7 input actions
  localparam int unsigned IRQ_W = 8;

  // standard source list; 15 selects the custom condition
  typedef enum logic [3:0] {
    SRC_NONE, SRC_L_PREALARM, SRC_L_TIMING, SRC_S_TIMING, SRC_L_TRIP,
    SRC_S_TRIP, SRC_G_TRIP, SRC_I_TRIP, SRC_ANY_TRIP,
    SRC_R9, SRC_R10, SRC_R11, SRC_R12, SRC_R13, SRC_R14, SRC_CUSTOM
  } src_sel_t;

  typedef enum logic [3:0] {
    ACT_GENERIC, ACT_OUTSIDE_TRIP, ACT_TRIP_RESET, ACT_ALT_SET,
    ACT_LOCAL_FORCE, ACT_SIGNAL_RESET, ACT_ENERGY_RESET
  } input_act_t;

  typedef struct packed {
    logic latch;
    logic nc;
    logic [SRC_W-1:0] src;
    logic [DELAY_W-1:0] delay;
  } contact_cfg_t;

  typedef struct packed {
    logic prealarm_l;
    logic timing_l;
    logic timing_s;
    logic trip_l;
    logic trip_s;
    logic trip_g;
    logic trip_i;
    logic trip_any;
  } release_cond_t;

  typedef struct packed {
    logic outside_trip;
    logic trip_reset;
    logic alt_set;
    logic local_force;
    logic energy_reset;
  } release_cmd_t;
endpackage : sig_pkg

// File: core/delay_timer.sv
// delay qualifier: condition must hold for a number of 10 ms ticks
`timescale 1ns/1ps
module delay_timer #(
  parameter int unsigned W = 14
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic tick, // 10 ms tick pulse
  input wire logic cond, // qualifying condition level
  input wire logic [W-1:0] delay, // delay in ticks
  output logic done // condition held for the full delay
);
  logic [W-1:0] count;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      done <= 1'b0;
    end else if (!cond) begin
      count <= '0; // [RL19] [RL9]
      done <= 1'b0;
    end else if (tick && !done) begin
      // zero delay fires on the first tick seen [RL19]
      if (count >= delay) begin
        done <= 1'b1; // [RL2] [RL8]
      end else begin
        count <= count + W'(1); // [RL18]
      end
    end
  end
endmodule : delay_timer

// File: core/signalling_contact_logic.sv
// four programmable relay contacts and one configurable input
// What this block does
// (RL1) four contacts, each fully separately configured
// (RL2) contact activates after delay, 0.01 s steps
// (RL3) normally-closed sense inverts the contact
// (RL4) latched contact stays on after source clears
// (RL5) latched contact released only by reset
// (RL6) source from standard list or custom
// (RL7) input polarity selects active level
// (RL8) input delay 0 to 100 s, 0.01 s; the 14-bit field takes up to 16383 steps, no limit at 10000
// (RL9) input must hold for whole delay
// (RL10) one selected action runs after delay
// (RL11) generic mode only reports input state
// (RL12) outside-trip mode commands breaker trip
// (RL13) trip-reset mode clears stored trip data
// (RL14) alternate-set mode selects the alternate set
// (RL15) local-force mode forces local communication
// (RL16) signalling-reset mode resets all four contacts
// (RL17) energy-reset mode clears energy meters
// (RL18) 10 ms tick; input synchronised first
// (RL19) counter restarts on drop; zero waits tick
`timescale 1ns/1ps
module signalling_contact_logic #(
  parameter int unsigned TICK_CYCLES = sig_pkg::TICK_CYCLES
) (
  input wire logic clk, // system clock, 50 MHz
  input wire logic rstn, // async reset, active low
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire sig_pkg::release_cond_t cond, // release conditions
  input wire logic [3:0] custom_cond, // custom condition per contact
  input wire logic input_pin, // raw digital input pin
  output logic contact_out_one, // relay contact 1 drive
  output logic contact_out_two, // relay contact 2 drive
  output logic contact_out_three, // relay contact 3 drive
  output logic contact_out_four, // relay contact 4 drive
  output sig_pkg::release_cmd_t cmd, // one-cycle commands to release
  output logic alt_set_active, // alternate parameter set selected
  output logic input_state, // polarity-adjusted input level report, taken before the delay
  output logic irq // level interrupt
);
  localparam int unsigned N = sig_pkg::NUM_CONTACTS;
  localparam int unsigned DW = sig_pkg::DELAY_W;
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  sig_pkg::contact_cfg_t ccfg [N];
  logic [DW-1:0] in_delay;
  sig_pkg::input_act_t in_act;
  logic in_pol;
  logic [sig_pkg::IRQ_W-1:0] irq_stat;
  logic [sig_pkg::IRQ_W-1:0] irq_mask;
  logic sw_reset;

  logic [TW-1:0] tick_cnt;
  logic tick;
  logic [2:0] sync;
  logic in_level;
  logic in_enabled;
  logic in_done;
  logic in_done_d;
  logic in_fire;
  logic contacts_reset;
  logic [6:0] act_hit;

  logic [N-1:0] src_true;
  logic [N-1:0] qual;
  logic [N-1:0] active;
  logic [N-1:0] active_d;
  logic [N-1:0] out_state;
  logic [sig_pkg::IRQ_W-1:0] irq_set;
  logic [31:0] status_word;

  // source decoding, shared by all four contacts [RL6]
  function automatic logic pick_src(input logic [3:0] sel,
                                    input sig_pkg::release_cond_t c,
                                    input logic custom);
    logic r;
    r = 1'b0;
    case (sig_pkg::src_sel_t'(sel))
      sig_pkg::SRC_L_PREALARM: r = c.prealarm_l;
      sig_pkg::SRC_L_TIMING: r = c.timing_l;
      sig_pkg::SRC_S_TIMING: r = c.timing_s;
      sig_pkg::SRC_L_TRIP: r = c.trip_l;
      sig_pkg::SRC_S_TRIP: r = c.trip_s;
      sig_pkg::SRC_G_TRIP: r = c.trip_g;
      sig_pkg::SRC_I_TRIP: r = c.trip_i;
      sig_pkg::SRC_ANY_TRIP: r = c.trip_any;
      sig_pkg::SRC_CUSTOM: r = custom;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick_src

  function automatic sig_pkg::contact_cfg_t to_ccfg(input logic [31:0] d);
    sig_pkg::contact_cfg_t c;
    c.delay = d[sig_pkg::CC_DELAY_LSB +: DW];
    c.src = d[sig_pkg::CC_SRC_LSB +: sig_pkg::SRC_W];
    c.nc = d[sig_pkg::CC_NC_BIT];
    c.latch = d[sig_pkg::CC_LATCH_BIT];
    return c;
  endfunction : to_ccfg

  function automatic logic [31:0] from_ccfg(input sig_pkg::contact_cfg_t c);
    logic [31:0] d;
    d = '0;
    d[sig_pkg::CC_DELAY_LSB +: DW] = c.delay;
    d[sig_pkg::CC_SRC_LSB +: sig_pkg::SRC_W] = c.src;
    d[sig_pkg::CC_NC_BIT] = c.nc;
    d[sig_pkg::CC_LATCH_BIT] = c.latch;
    return d;
  endfunction : from_ccfg

  // one-hot decode of the action that fires; codes above 6 do nothing
  function automatic logic [6:0] decode_act(input sig_pkg::input_act_t a,
                                            input logic fire);
    logic [6:0] h;
    h = 7'h00;
    if (fire) begin
      unique case (a)
        sig_pkg::ACT_GENERIC: h[0] = 1'b1;
        sig_pkg::ACT_OUTSIDE_TRIP: h[1] = 1'b1;
        sig_pkg::ACT_TRIP_RESET: h[2] = 1'b1;
        sig_pkg::ACT_ALT_SET: h[3] = 1'b1;
        sig_pkg::ACT_LOCAL_FORCE: h[4] = 1'b1;
        sig_pkg::ACT_SIGNAL_RESET: h[5] = 1'b1;
        sig_pkg::ACT_ENERGY_RESET: h[6] = 1'b1;
        default: h = 7'h00;
      endcase
    end
    return h;
  endfunction : decode_act

  function automatic logic [31:0] from_icfg(input logic [DW-1:0] dly,
                                            input sig_pkg::input_act_t a,
                                            input logic pol);
    logic [31:0] d;
    d = '0;
    d[sig_pkg::IC_DELAY_LSB +: DW] = dly;
    d[sig_pkg::IC_ACT_LSB +: 4] = a;
    d[sig_pkg::IC_POL_BIT] = pol;
    return d;
  endfunction : from_icfg

  // 10 ms timebase for all delay counters
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1; // [RL18]
    end else begin
      tick_cnt <= tick_cnt + TW'(1);
      tick <= 1'b0;
    end
  end

  // input pin: three stages, level accepted when last two agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync <= '0;
      in_level <= 1'b0;
    end else begin
      sync <= {sync[1:0], input_pin}; // [RL18]
      if (sync[1] == sync[2]) begin
        in_level <= sync[2];
      end
    end
  end

  assign in_enabled = in_pol ? in_level : ~in_level; // [RL7]

  delay_timer #(.W(DW)) u_in_timer (
    .clk(clk),
    .rstn(rstn),
    .tick(tick),
    .cond(in_enabled),
    .delay(in_delay),
    .done(in_done)
  );

  // action fires once per qualified assertion [RL9] [RL10]
  assign in_fire = in_done & ~in_done_d;
  assign act_hit = decode_act(in_act, in_fire); // [RL10]
  assign contacts_reset = sw_reset | act_hit[5]; // [RL16]

  // commands are one-cycle pulses; the release acts on the edge it sees
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_done_d <= 1'b0;
      cmd <= '0;
      input_state <= 1'b0;
    end else begin
      in_done_d <= in_done;
      input_state <= in_enabled; // [RL11]
      cmd.outside_trip <= act_hit[1]; // [RL12]
      cmd.trip_reset <= act_hit[2]; // [RL13]
      cmd.alt_set <= act_hit[3]; // [RL14]
      cmd.local_force <= act_hit[4]; // [RL15]
      cmd.energy_reset <= act_hit[6]; // [RL17]
    end
  end

  // alternate set stays chosen; nothing but reset returns to primary
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alt_set_active <= 1'b0;
    end else if (act_hit[3]) begin
      alt_set_active <= 1'b1; // [RL14]
    end
  end

  // contact channels [RL1]
  for (genvar i = 0; i < N; i++) begin : g_contact
    assign src_true[i] = pick_src(ccfg[i].src, cond, custom_cond[i]); // [RL6]

    delay_timer #(.W(DW)) u_timer (
      .clk(clk),
      .rstn(rstn),
      .tick(tick),
      .cond(src_true[i]),
      .delay(ccfg[i].delay),
      .done(qual[i])
    );

    // latch holds until a contact reset; reset wins over a new activation
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        active[i] <= 1'b0;
      end else if (contacts_reset) begin
        active[i] <= 1'b0; // [RL5] [RL16]
      end else if (qual[i]) begin
        active[i] <= 1'b1; // [RL2]
      end else if (!ccfg[i].latch) begin
        active[i] <= 1'b0;
      end else begin
        active[i] <= active[i]; // [RL4]
      end
    end
    assign out_state[i] = active[i] ^ ccfg[i].nc; // [RL3]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      contact_out_one <= 1'b0;
      contact_out_two <= 1'b0;
      contact_out_three <= 1'b0;
      contact_out_four <= 1'b0;
      active_d <= '0;
    end else begin
      contact_out_one <= out_state[0];
      contact_out_two <= out_state[1];
      contact_out_three <= out_state[2];
      contact_out_four <= out_state[3];
      active_d <= active;
    end
  end

  // contact bits flag a rise of the activation, not its level
  assign irq_set = {cmd.energy_reset | act_hit[5],
                    cmd.local_force | cmd.alt_set,
                    cmd.trip_reset,
                    cmd.outside_trip | act_hit[0],
                    active & ~active_d};

  // live state for software; alt_set_active holds until reset, latched contact bits until a contact reset
  assign status_word = {20'h00000, alt_set_active, in_done, in_enabled,
                        in_level, out_state, active}; // [RL11]

  // software contact reset acts one cycle after the write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sw_reset <= 1'b0;
    end else begin
      sw_reset <= wr && addr == sig_pkg::ADDR_CMD &&
        wdata[sig_pkg::CMD_RESET_BIT]; // [RL5]
    end
  end

  // register writes; config takes effect on the next cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k < N; k++) begin
        ccfg[k] <= to_ccfg(sig_pkg::CONTACT_RESET);
      end
      in_delay <= sig_pkg::INPUT_RESET[sig_pkg::IC_DELAY_LSB +: DW];
      in_act <= sig_pkg::input_act_t'(
        sig_pkg::INPUT_RESET[sig_pkg::IC_ACT_LSB +: 4]);
      in_pol <= sig_pkg::INPUT_RESET[sig_pkg::IC_POL_BIT];
      irq_mask <= sig_pkg::IRQ_MASK_RESET;
    end else begin
      if (wr) begin
        unique case (addr)
          sig_pkg::ADDR_CONTACT0: ccfg[0] <= to_ccfg(wdata);
          sig_pkg::ADDR_CONTACT1: ccfg[1] <= to_ccfg(wdata);
          sig_pkg::ADDR_CONTACT2: ccfg[2] <= to_ccfg(wdata);
          sig_pkg::ADDR_CONTACT3: ccfg[3] <= to_ccfg(wdata);
          sig_pkg::ADDR_INPUT_CFG: begin
            in_delay <= wdata[sig_pkg::IC_DELAY_LSB +: DW];
            in_act <= sig_pkg::input_act_t'(wdata[sig_pkg::IC_ACT_LSB +: 4]);
            in_pol <= wdata[sig_pkg::IC_POL_BIT];
          end
          sig_pkg::ADDR_IRQ_MASK: irq_mask <= wdata[sig_pkg::IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // sticky status: a new event in the clearing cycle survives
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat <= '0;
    end else begin
      if (wr && addr == sig_pkg::ADDR_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~wdata[sig_pkg::IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
    end
  end

  // the line follows status and mask one cycle late, straight from a flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        sig_pkg::ADDR_CONTACT0: rdata <= from_ccfg(ccfg[0]);
        sig_pkg::ADDR_CONTACT1: rdata <= from_ccfg(ccfg[1]);
        sig_pkg::ADDR_CONTACT2: rdata <= from_ccfg(ccfg[2]);
        sig_pkg::ADDR_CONTACT3: rdata <= from_ccfg(ccfg[3]);
        sig_pkg::ADDR_INPUT_CFG: rdata <= from_icfg(in_delay, in_act, in_pol);
        sig_pkg::ADDR_STATUS: rdata <= status_word;
        sig_pkg::ADDR_IRQ_STAT: rdata <= 32'(irq_stat);
        sig_pkg::ADDR_IRQ_MASK: rdata <= 32'(irq_mask);
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule : signalling_contact_logic

// File: verif/sig_checker.sv
// port-level assertions for the signalling contact logic
`timescale 1ns/1ps
module sig_checker #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic clk, // clock
  input wire logic rstn, // reset, low
  input wire logic rd, // read strobe
  input wire logic [31:0] rdata, // read data
  input wire sig_pkg::release_cmd_t cmd, // commands
  input wire logic alt_set_active, // set b
  input wire logic input_state, // input report
  input wire logic irq, // interrupt
  input wire logic contact_out_one, // contact 1
  input wire logic contact_out_two, // contact 2
  input wire logic contact_out_three, // contact 3
  input wire logic contact_out_four // contact 4
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");
  AST_REST_AFTER_RESET: assert property ($rose(rstn) |->
    !(contact_out_one | contact_out_two | contact_out_three |
    contact_out_four | irq) && cmd == 5'h00)
    else $error("outputs not at rest after reset");
  AST_ONE_ACTION: assert property ($onehot0(cmd))
    else $error("more than one action at once");
  // a repeat needs a drop and a new pass through the synchroniser
  AST_CMD_GAP: assert property (cmd != 5'h00 |=> cmd == 5'h00 [*4])
    else $error("action not a lone pulse");
  AST_ALT_STICKY: assert property ($past(alt_set_active) |-> alt_set_active)
    else $error("alternate set dropped");
  AST_ALT_AFTER_CMD: assert property (cmd.alt_set |-> ##[0:2] alt_set_active)
    else $error("alternate set not taken");
  AST_CMD_NEEDS_INPUT: assert property (cmd != 5'h00 |->
    input_state || $past(input_state) || $past(input_state, 2))
    else $error("action without enabled input");
  AST_NO_TRIP_UNTIL_ACT: assert property ($rose(rstn) |->
    cmd == 5'h00 [*4])
    else $error("action right after reset");
  cover property (cmd.outside_trip);
  cover property ($rose(alt_set_active));
  cover property ($fell(contact_out_two));
  cover property (irq);
endmodule : sig_checker

bind signalling_contact_logic sig_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clk(clk), .rstn(rstn), .rd(rd), .rdata(rdata), .cmd(cmd),
  .alt_set_active(alt_set_active), .input_state(input_state), .irq(irq),
  .contact_out_one(contact_out_one), .contact_out_two(contact_out_two),
  .contact_out_three(contact_out_three), .contact_out_four(contact_out_four)
);

// File: verif/release_model.sv
// behavioural protection release: offers conditions, logs commands
`timescale 1ns/1ps
module release_model (
  input wire logic clk, // clock
  input wire logic rstn, // reset, low
  input wire sig_pkg::release_cmd_t cmd, // commands in
  output sig_pkg::release_cond_t cond, // conditions out
  output logic [3:0] custom_cond // custom conditions
);
  logic [4:0] seen = 5'h00; // commands taken since last clear
  initial begin
    cond = 8'h00;
    custom_cond = 4'h0;
  end
  always @(posedge clk) begin
    if (rstn && cmd != 5'h00) begin
      seen <= seen | cmd;
    end
  end
  // conditions change only just after an edge, like the real release
  task automatic set_cond(input logic [7:0] c, input logic [3:0] cu);
    @(posedge clk);
    cond <= c;
    custom_cond <= cu;
  endtask : set_cond
endmodule : release_model

// File: verif/signalling_contact_logic_tb_top.sv
// self-checking bench for the signalling contact logic
`timescale 1ns/1ps
module signalling_contact_logic_tb_top;
  localparam int unsigned TK = 10;
  typedef struct packed {
    logic [1:0] idx;
    logic [3:0] src;
    logic [7:0] c;
    logic [3:0] cu;
    logic nc;
    logic exp;
  } row_t;
  logic clk, rstn, wr, rd, input_pin;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  sig_pkg::release_cond_t cond;
  sig_pkg::release_cmd_t cmd;
  logic [3:0] custom_cond, outs;
  logic contact_out_one, contact_out_two, contact_out_three, contact_out_four;
  logic alt_set_active, input_state, irq;
  int error_cnt = 0;
  int checks = 0;
  row_t rows [12] = '{
    '{2'h0, 4'h1, 8'h80, 4'h0, 1'b0, 1'b1}, '{2'h1, 4'h2, 8'h40, 4'h0, 1'b0, 1'b1},
    '{2'h2, 4'h3, 8'h20, 4'h0, 1'b1, 1'b0}, '{2'h3, 4'h4, 8'h10, 4'h0, 1'b0, 1'b1},
    '{2'h0, 4'h5, 8'h08, 4'h0, 1'b1, 1'b0}, '{2'h1, 4'h6, 8'h04, 4'h0, 1'b0, 1'b1},
    '{2'h2, 4'h7, 8'h02, 4'h0, 1'b0, 1'b1}, '{2'h3, 4'h8, 8'h01, 4'h0, 1'b0, 1'b1},
    '{2'h0, 4'hF, 8'h00, 4'h1, 1'b0, 1'b1}, '{2'h1, 4'hF, 8'hFF, 4'h1, 1'b0, 1'b0},
    '{2'h2, 4'h0, 8'hFF, 4'hF, 1'b1, 1'b1}, '{2'h3, 4'h9, 8'hFF, 4'hF, 1'b0, 1'b0}};
  logic [4:0] exp_cmd [7] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h02, 5'h00, 5'h01};
  assign outs = {contact_out_four, contact_out_three, contact_out_two,
    contact_out_one};
  signalling_contact_logic #(.TICK_CYCLES(TK)) dut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cond(cond), .custom_cond(custom_cond),
    .input_pin(input_pin), .contact_out_one(contact_out_one),
    .contact_out_two(contact_out_two), .contact_out_three(contact_out_three),
    .contact_out_four(contact_out_four), .cmd(cmd),
    .alt_set_active(alt_set_active), .input_state(input_state), .irq(irq));
  release_model rel (.clk(clk), .rstn(rstn), .cmd(cmd), .cond(cond),
    .custom_cond(custom_cond));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk
  function automatic logic [31:0] ccfg(input logic [3:0] s, input logic nc,
    input logic lt, input logic [13:0] d);
    return {10'h000, lt, nc, s, 2'h0, d};
  endfunction : ccfg
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #(20 * 20000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    input_pin = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
    check(32'(outs), 32'h0);
    cyc(20);
    check(32'(input_state), 32'h1);
    check(32'(rel.seen), 32'h0);
    rd_chk(8'h00, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      wr_reg(8'({rows[i].idx, 2'h0}), ccfg(rows[i].src, rows[i].nc, 1'b0,
        14'h0));
      rel.set_cond(rows[i].c, rows[i].cu);
      cyc(40);
      check(32'(outs[rows[i].idx]), 32'(rows[i].exp));
      rel.set_cond(8'h00, 4'h0);
      wr_reg(8'({rows[i].idx, 2'h0}), 32'h0);
    end
    $display("source table test done");
    wr_reg(8'h00, ccfg(4'h8, 1'b0, 1'b0, 14'h5));
    rel.set_cond(8'h01, 4'h0);
    cyc(35);
    check(32'(contact_out_one), 32'h0);
    rel.set_cond(8'h00, 4'h0);
    rel.set_cond(8'h01, 4'h0);
    cyc(35);
    check(32'(contact_out_one), 32'h0);
    cyc(40);
    check(32'(contact_out_one), 32'h1);
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h04, ccfg(4'h8, 1'b0, 1'b1, 14'h0));
    cyc(30);
    rel.set_cond(8'h00, 4'h0);
    cyc(30);
    check(32'(contact_out_two), 32'h1);
    wr_reg(8'h20, 32'h1);
    cyc(3);
    check(32'(contact_out_two), 32'h0);
    rel.set_cond(8'h01, 4'h0);
    cyc(30);
    rel.set_cond(8'h00, 4'h0);
    cyc(30);
    check(32'(contact_out_two), 32'h1);
    $display("delay and latch test done");
    wr_reg(8'h1C, 32'hFF);
    wr_reg(8'h18, 32'hFF);
    for (int a = 0; a < 7; a++) begin
      rel.seen = 5'h00;
      wr_reg(8'h10, {11'h000, 1'b1, 4'(a), 2'h0, 14'h3});
      input_pin <= 1'b1;
      cyc(70);
      check(32'(input_state), 32'h1);
      check(32'(rel.seen), 32'(exp_cmd[a]));
      @(posedge clk);
      input_pin <= 1'b0;
      cyc(20);
    end
    check(32'(alt_set_active), 32'h1);
    check(32'(contact_out_two), 32'h0);
    rel.seen = 5'h00;
    wr_reg(8'h10, {11'h000, 1'b1, 4'h1, 2'h0, 14'h5});
    input_pin <= 1'b1;
    cyc(30);
    @(posedge clk);
    input_pin <= 1'b0;
    cyc(80);
    check(32'(rel.seen), 32'h0);
    $display("input action test done");
    check(32'(irq), 32'h1);
    rd_chk(8'h18, 32'hF0);
    wr_reg(8'h1C, 32'h0);
    cyc(3);
    check(32'(irq), 32'h0);
    wr_reg(8'h18, 32'hFF);
    wr_reg(8'h1C, 32'hFF);
    cyc(3);
    check(32'(irq), 32'h0);
    rd_chk(8'h10, 32'h0011_0005);
    rd_chk(8'h14, 32'h0000_0800);
    rd_chk(8'h3C, 32'h0);
    $display("interrupt test done");
    tally_and_finish();
  end
endmodule : signalling_contact_logic_tb_top
